// ===== hdl/ledi2c_top.sv
// Target-side two-wire serial port of a dual-sink LED boost converter.
// Assumes an external controller drives the serial clock and pull-ups on both lines.
`timescale 1ns/100ps
`include "ledi2c_params.svh"
module ledi2c_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Bus status
    output logic bus_busy_o,
    // Converter controls
    output logic primary_sink_enable_o,
    output logic secondary_sink_enable_o,
    output logic shared_brightness_select_o,
    output logic [1:0] ramp_rate_o,
    output logic display_bias_mode_o,
    output logic [4:0] primary_current_o,
    output logic [4:0] secondary_current_o,
    output logic [7:0] general_io_o
);
    logic [1:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic scl_d_ff;
    logic sda_d_ff;
    ledi2c_pkg::ledi2c_state_t state_ff;
    ledi2c_pkg::ledi2c_state_t nxt_state;
    logic [3:0] bit_ff;
    logic [3:0] nxt_bit;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] raddr_ff;
    logic [7:0] nxt_raddr;
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;
    logic pull_ff;
    logic nxt_pull;
    logic busy_ff;
    logic nxt_busy;
    logic wr_ff;
    logic nxt_wr;
    logic [7:0] wdata_ff;
    logic [7:0] nxt_wdata;
    logic [7:0] rdata;
    logic [7:0] gc;
    logic [7:0] pb;
    logic [7:0] sb;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;

    ledi2c_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i({scl_i, sda_i}),
        .sync_o(pins_sync)
    );

    ledi2c_regs u_regs (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_ff),
        .addr_i(raddr_ff),
        .wdata_i(wdata_ff),
        .rdata_o(rdata),
        .general_control_o(gc),
        .general_io_o(general_io_o),
        .primary_brightness_o(pb),
        .secondary_brightness_o(sb)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];
    assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;

    // phase: 0 expects device address, 1 register offset, 2 data bytes
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bit = bit_ff;
        nxt_shift = shift_ff;
        nxt_raddr = raddr_ff;
        nxt_phase = phase_ff;
        nxt_pull = pull_ff;
        nxt_busy = busy_ff;
        nxt_wr = 1'b0;
        nxt_wdata = wdata_ff;
        if (stop_det)
        begin
            nxt_busy = 1'b0;
            nxt_state = ledi2c_pkg::ST_IDLE;
            nxt_pull = 1'b0;
        end
        else if (start_det)
        begin
            // A repeated start restarts address reception
            nxt_busy = 1'b1;
            nxt_state = ledi2c_pkg::ST_ADDR;
            nxt_phase = 2'd0;
            nxt_bit = 4'd0;
            nxt_pull = 1'b0;
        end
        else
        begin
            case (state_ff)
                ledi2c_pkg::ST_IDLE:
                begin
                    nxt_pull = 1'b0;
                end
                ledi2c_pkg::ST_ADDR, ledi2c_pkg::ST_REG, ledi2c_pkg::ST_DATA:
                begin
                    // Sample on the rising clock edge, when data is steady
                    if (scl_rise)
                    begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit = bit_ff + 4'd1;
                    end
                    else if (scl_fall && bit_ff == 4'd8)
                    begin
                        nxt_bit = 4'd0;
                        nxt_state = ledi2c_pkg::ST_ACK;
                        if (state_ff == ledi2c_pkg::ST_ADDR)
                        begin
                            // Foreign address: stay silent until the next start
                            if (shift_ff[7:1] == `LEDI2C_DEV_ADDR)
                            begin
                                nxt_pull = 1'b1;
                                nxt_phase = shift_ff[0] ? 2'd3 : 2'd1;
                            end
                            else
                            begin
                                nxt_state = ledi2c_pkg::ST_IDLE;
                            end
                        end
                        else if (state_ff == ledi2c_pkg::ST_REG)
                        begin
                            nxt_raddr = shift_ff;
                            nxt_pull = 1'b1;
                            nxt_phase = 2'd2;
                        end
                        else
                        begin
                            nxt_wdata = shift_ff;
                            nxt_wr = 1'b1;
                            nxt_pull = 1'b1;
                            nxt_phase = 2'd2;
                        end
                    end
                end
                ledi2c_pkg::ST_ACK:
                begin
                    // Release, or drive the first read bit, after the ninth pulse ends, while the clock is low
                    if (scl_fall)
                    begin
                        nxt_bit = 4'd0;
                        if (phase_ff == 2'd3)
                        begin
                            nxt_state = ledi2c_pkg::ST_READ;
                            nxt_shift = rdata;
                            nxt_pull = !rdata[7];
                        end
                        else
                        begin
                            nxt_pull = 1'b0;
                            nxt_state = (phase_ff == 2'd1) ? ledi2c_pkg::ST_REG : ledi2c_pkg::ST_DATA;
                        end
                    end
                end
                ledi2c_pkg::ST_READ:
                begin
                    if (scl_fall)
                    begin
                        nxt_bit = bit_ff + 4'd1;
                        if (bit_ff == 4'd7)
                        begin
                            nxt_pull = 1'b0;
                            nxt_state = ledi2c_pkg::ST_RACK;
                        end
                        else
                        begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_pull = !shift_ff[6];
                        end
                    end
                end
                ledi2c_pkg::ST_RACK:
                begin
                    // Controller acknowledge continues the read; no acknowledge ends it
                    if (scl_rise)
                    begin
                        nxt_state = sda_s ? ledi2c_pkg::ST_IDLE : ledi2c_pkg::ST_ACK;
                        nxt_phase = 2'd3;
                    end
                end
                default:
                begin
                    nxt_state = ledi2c_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            state_ff <= ledi2c_pkg::ST_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            raddr_ff <= 8'h00;
            phase_ff <= 2'h0;
            pull_ff <= 1'b0;
            busy_ff <= 1'b0;
            wr_ff <= 1'b0;
            wdata_ff <= 8'h00;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            state_ff <= nxt_state;
            bit_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            raddr_ff <= nxt_raddr;
            phase_ff <= nxt_phase;
            pull_ff <= nxt_pull;
            busy_ff <= nxt_busy;
            wr_ff <= nxt_wr;
            wdata_ff <= nxt_wdata;
        end
    end

    // Open drain: only ever pulls low, never forms start or stop itself
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !pull_ff;
    assign bus_busy_o = busy_ff;

    assign primary_sink_enable_o = gc[`LEDI2C_BIT_PRIMARY_SINK_ENABLE];
    assign secondary_sink_enable_o = gc[`LEDI2C_BIT_SECONDARY_SINK_ENABLE];
    assign shared_brightness_select_o = gc[`LEDI2C_BIT_SHARED_BRIGHTNESS_SELECT];
    assign ramp_rate_o = {gc[`LEDI2C_BIT_RAMP_RATE_HIGH], gc[`LEDI2C_BIT_RAMP_RATE_LOW]};
    assign display_bias_mode_o = gc[`LEDI2C_BIT_DISPLAY_BIAS_MODE];
    assign primary_current_o = pb[`LEDI2C_BRIGHT_MSB:0];
    assign secondary_current_o = shared_brightness_select_o ? pb[`LEDI2C_BRIGHT_MSB:0]
                                                             : sb[`LEDI2C_BRIGHT_MSB:0];
endmodule

// ===== hdl/ledi2c_params.svh
// Register map, field positions and reset values of the LED driver serial port.
// Included by the top, synchroniser and register files; definitions only.
`ifndef LEDI2C_PARAMS_SVH
`define LEDI2C_PARAMS_SVH

`define LEDI2C_DEV_ADDR 7'h36
`define LEDI2C_OFS_GENERAL_CONTROL 8'h10
`define LEDI2C_OFS_GENERAL_IO 8'h80
`define LEDI2C_OFS_PRIMARY_BRIGHTNESS 8'ha0
`define LEDI2C_OFS_SECONDARY_BRIGHTNESS 8'hb0
`define LEDI2C_RST_GENERAL_CONTROL 8'hc0
`define LEDI2C_RST_GENERAL_IO 8'hf8
`define LEDI2C_RST_PRIMARY_BRIGHTNESS 8'he0
`define LEDI2C_RST_SECONDARY_BRIGHTNESS 8'he0
`define LEDI2C_GC_WMASK 8'h3f
`define LEDI2C_GC_FIXED_ONES 8'hc0
`define LEDI2C_BIT_PRIMARY_SINK_ENABLE 0
`define LEDI2C_BIT_SECONDARY_SINK_ENABLE 1
`define LEDI2C_BIT_SHARED_BRIGHTNESS_SELECT 2
`define LEDI2C_BIT_RAMP_RATE_LOW 3
`define LEDI2C_BIT_RAMP_RATE_HIGH 4
`define LEDI2C_BIT_DISPLAY_BIAS_MODE 5
`define LEDI2C_BRIGHT_MSB 4
`define LEDI2C_SYNC_STAGES 2

`endif

// ===== hdl/ledi2c_pkg.sv
// Types shared by the LED driver serial port.
// Takes no numbers from ledi2c_params.svh.
package ledi2c_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_DATA,
        ST_READ,
        ST_ACK,
        ST_RACK
    } ledi2c_state_t;
endpackage

// ===== hdl/ledi2c_sync.sv
// Two-flop synchronisers for the serial clock and data pins.
// Assumes asynchronous pin levels; resets to the idle-high bus level.
`timescale 1ns/100ps
`include "ledi2c_params.svh"
module ledi2c_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Raw pins
    input wire logic [1:0] pin_i,
    // Synchronised levels
    output logic [1:0] sync_o
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] nxt_meta;
    logic [1:0] nxt_sync;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_bit
            always_comb
            begin
                nxt_meta[g] = pin_i[g];
                nxt_sync[g] = meta_ff[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;
endmodule

// ===== hdl/ledi2c_regs.sv
// Four 8-bit configuration registers with power-on defaults.
// Assumes one write strobe per stored byte from the serial engine.
`timescale 1ns/100ps
`include "ledi2c_params.svh"
module ledi2c_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Write and read port
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // Register contents
    output logic [7:0] general_control_o,
    output logic [7:0] general_io_o,
    output logic [7:0] primary_brightness_o,
    output logic [7:0] secondary_brightness_o
);
    logic [7:0] gc_ff;
    logic [7:0] gio_ff;
    logic [7:0] pb_ff;
    logic [7:0] sb_ff;
    logic [7:0] rd_ff;
    logic [7:0] nxt_gc;
    logic [7:0] nxt_gio;
    logic [7:0] nxt_pb;
    logic [7:0] nxt_sb;
    logic [7:0] nxt_rd;

    always_comb
    begin
        nxt_gc = gc_ff;
        nxt_gio = gio_ff;
        nxt_pb = pb_ff;
        nxt_sb = sb_ff;
        // Unknown offsets store nothing
        if (wr_i)
        begin
            if (addr_i == `LEDI2C_OFS_GENERAL_CONTROL)
                nxt_gc = (wdata_i & `LEDI2C_GC_WMASK) | `LEDI2C_GC_FIXED_ONES;
            else if (addr_i == `LEDI2C_OFS_GENERAL_IO)
                nxt_gio = wdata_i;
            else if (addr_i == `LEDI2C_OFS_PRIMARY_BRIGHTNESS)
                nxt_pb = wdata_i;
            else if (addr_i == `LEDI2C_OFS_SECONDARY_BRIGHTNESS)
                nxt_sb = wdata_i;
        end
        if (addr_i == `LEDI2C_OFS_GENERAL_CONTROL)
            nxt_rd = gc_ff;
        else if (addr_i == `LEDI2C_OFS_GENERAL_IO)
            nxt_rd = gio_ff;
        else if (addr_i == `LEDI2C_OFS_PRIMARY_BRIGHTNESS)
            nxt_rd = pb_ff;
        else if (addr_i == `LEDI2C_OFS_SECONDARY_BRIGHTNESS)
            nxt_rd = sb_ff;
        else
            nxt_rd = 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            gc_ff <= `LEDI2C_RST_GENERAL_CONTROL;
            gio_ff <= `LEDI2C_RST_GENERAL_IO;
            pb_ff <= `LEDI2C_RST_PRIMARY_BRIGHTNESS;
            sb_ff <= `LEDI2C_RST_SECONDARY_BRIGHTNESS;
            rd_ff <= 8'h00;
        end
        else
        begin
            gc_ff <= nxt_gc;
            gio_ff <= nxt_gio;
            pb_ff <= nxt_pb;
            sb_ff <= nxt_sb;
            rd_ff <= nxt_rd;
        end
    end

    assign rdata_o = rd_ff;
    assign general_control_o = gc_ff;
    assign general_io_o = gio_ff;
    assign primary_brightness_o = pb_ff;
    assign secondary_brightness_o = sb_ff;
endmodule

// ===== bench/ledi2c_top_assertions.sv
// Port checker of the LED driver serial port, bound into ledi2c_top.
// Assumes one clock domain and a raw, pulled-up serial bus at the pins.
`timescale 1ns/100ps
module ledi2c_top_assertions (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    // Status and controls
    input wire logic bus_busy_o,
    input wire logic shared_brightness_select_o,
    input wire logic [4:0] primary_current_o,
    input wire logic [4:0] secondary_current_o,
    input wire logic [7:0] general_io_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Clock held high long enough for the synchronisers to see the edge
    sequence s_start;
        ($fell(sda_i) && scl_i) ##1 scl_i [*6];
    endsequence
    sequence s_stop;
        ($rose(sda_i) && scl_i) ##1 (scl_i && sda_i) [*6];
    endsequence
    property p_reset_vals;
        disable iff (1'h0) !rstn_i |=> sda_oe_n_o && !bus_busy_o && general_io_o == 8'hf8
            && primary_current_o == 5'h00 && !shared_brightness_select_o;
    endproperty
    property p_open_drain;
        sda_o == 1'h0;
    endproperty
    property p_start_busy;
        s_start |=> bus_busy_o;
    endproperty
    property p_stop_idle;
        s_stop |=> !bus_busy_o;
    endproperty
    property p_pull_scl_low;
        $changed(sda_oe_n_o) |-> !scl_i;
    endproperty
    property p_pull_hold;
        $fell(sda_oe_n_o) |=> !sda_oe_n_o [*8];
    endproperty
    property p_idle_release;
        !bus_busy_o |-> sda_oe_n_o;
    endproperty
    property p_shared;
        shared_brightness_select_o && $past(shared_brightness_select_o) |-> secondary_current_o == primary_current_o;
    endproperty
    // Stored values may only move while the byte is being acknowledged
    property p_update_in_ack;
        $changed(general_io_o) || $changed(primary_current_o) |-> !sda_oe_n_o;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    a_start_busy: assert property (p_start_busy) else $error("start not seen");
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
    a_pull_scl_low: assert property (p_pull_scl_low) else $error("data moved with clock high");
    a_pull_hold: assert property (p_pull_hold) else $error("pull too short");
    a_idle_release: assert property (p_idle_release) else $error("pull on idle bus");
    a_shared: assert property (p_shared) else $error("shared current differs");
    a_update_in_ack: assert property (p_update_in_ack) else $error("register moved outside ack");
endmodule
bind ledi2c_top ledi2c_top_assertions u_ledi2c_top_assertions (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .bus_busy_o(bus_busy_o), .shared_brightness_select_o(shared_brightness_select_o),
    .primary_current_o(primary_current_o), .secondary_current_o(secondary_current_o),
    .general_io_o(general_io_o)
);

// ===== bench/ledi2c_ctrl_model.sv
// Behavioural two-wire bus controller for the serial port.
// Assumes a pull-up on data: a released line floats high.
`timescale 1ns/100ps
module ledi2c_ctrl_model #(
    parameter int PHASE = 20
) (
    // Clock
    input wire logic clk_i,
    // Bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_rel_o
);
    initial
    begin
        scl_o = 1'h1;
        sda_rel_o = 1'h1;
    end
    // A phase well above the port's pin latency
    task automatic step(input logic c, input logic d);
        @(posedge clk_i);
        scl_o <= c;
        sda_rel_o <= d;
        repeat (PHASE) @(posedge clk_i);
    endtask
    task automatic start_cond();
        step(1'h0, sda_rel_o);
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        step(1'h1, 1'h0);
        step(1'h0, 1'h0);
    endtask
    task automatic stop_cond();
        step(1'h0, 1'h0);
        step(1'h1, 1'h0);
        step(1'h1, 1'h1);
    endtask
    task automatic bit_xfer(input logic b, output logic r);
        step(1'h0, b);
        step(1'h1, b);
        #1 r = sda_i;
        step(1'h0, b);
    endtask
    task automatic byte_out(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(v[i], r);
        bit_xfer(1'h1, r);
        ack = !r;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'h1, v[i]);
        bit_xfer(last, r);
    endtask
endmodule

// ===== bench/ledi2c_top_bench.sv
// Self-checking bench of the LED driver serial port.
// Drives the pins through the controller model; the data wire is pulled up.
`timescale 1ns/100ps
module ledi2c_top_bench;
    logic clk_i = 1'h0;
    logic rstn_i;
    logic scl, sda_rel, sda_o, sda_oe_n_o, bus_busy_o, pse, sse, shs, dbm, ack;
    logic [1:0] ramp;
    logic [4:0] pcur, scur;
    logic [7:0] gio, v, sh_gc, sh_gio, sh_pri, sh_sec;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // Offset, data written, value read back
    logic [23:0] rows [6] = '{24'h10ffff, 24'ha0f5f5, 24'hb00a0a, 24'h1003c3, 24'h805a5a, 24'h103cfc};
    wire sda_w = sda_rel & (sda_oe_n_o ? 1'h1 : sda_o);
    always #2.5 clk_i = ~clk_i;
    ledi2c_top u_ledi2c_top (
        .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .bus_busy_o(bus_busy_o), .primary_sink_enable_o(pse), .secondary_sink_enable_o(sse),
        .shared_brightness_select_o(shs), .ramp_rate_o(ramp), .display_bias_mode_o(dbm),
        .primary_current_o(pcur), .secondary_current_o(scur), .general_io_o(gio)
    );
    ledi2c_ctrl_model u_ledi2c_ctrl_model (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_rel_o(sda_rel));
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic defaults();
        sh_gc = 8'hc0;
        sh_gio = 8'hf8;
        sh_pri = 8'he0;
        sh_sec = 8'he0;
    endtask
    task automatic model(input logic [7:0] ofs, input logic [7:0] dat);
        case (ofs)
            8'h10: sh_gc = dat | 8'hc0;
            8'h80: sh_gio = dat;
            8'ha0: sh_pri = dat;
            8'hb0: sh_sec = dat;
            default: ;
        endcase
    endtask
    task automatic check_outs();
        check({2'h3, dbm, ramp, shs, sse, pse}, sh_gc);
        check(gio, sh_gio);
        check({3'h0, pcur}, {3'h0, sh_pri[4:0]});
        check({3'h0, scur}, {3'h0, sh_gc[2] ? sh_pri[4:0] : sh_sec[4:0]});
        check({7'h0, bus_busy_o}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] dat);
        logic a1, a2, a3;
        u_ledi2c_ctrl_model.start_cond();
        u_ledi2c_ctrl_model.byte_out(dev, a1);
        u_ledi2c_ctrl_model.byte_out(ofs, a2);
        u_ledi2c_ctrl_model.byte_out(dat, a3);
        u_ledi2c_ctrl_model.stop_cond();
        ack = a1 & a2 & a3;
    endtask
    task automatic rd(input logic [7:0] ofs);
        logic a;
        u_ledi2c_ctrl_model.start_cond();
        u_ledi2c_ctrl_model.byte_out(8'h6c, a);
        u_ledi2c_ctrl_model.byte_out(ofs, a);
        u_ledi2c_ctrl_model.start_cond();
        u_ledi2c_ctrl_model.byte_out(8'h6d, a);
        u_ledi2c_ctrl_model.byte_in(1'h1, v);
        u_ledi2c_ctrl_model.stop_cond();
    endtask
    // Cut a hang short well past the expected run of about 40k cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        rstn_i = 1'h0;
        defaults();
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        check_outs();
        foreach (rows[i])
        begin
            wr(8'h6c, rows[i][23:16], rows[i][15:8]);
            check({7'h0, ack}, 8'h01);
            model(rows[i][23:16], rows[i][15:8]);
            check_outs();
            rd(rows[i][23:16]);
            check(v, rows[i][7:0]);
        end
        // Unknown offset is acknowledged but stores nothing
        wr(8'h6c, 8'h20, 8'h55);
        check({7'h0, ack}, 8'h01);
        check_outs();
        wr(8'h6e, 8'ha0, 8'h1f);
        check({7'h0, ack}, 8'h00);
        check_outs();
        // Extra data bytes go to the same register
        u_ledi2c_ctrl_model.start_cond();
        u_ledi2c_ctrl_model.byte_out(8'h6c, ack);
        u_ledi2c_ctrl_model.byte_out(8'hb0, ack);
        u_ledi2c_ctrl_model.byte_out(8'h11, ack);
        u_ledi2c_ctrl_model.byte_out(8'h12, ack);
        check({7'h0, bus_busy_o}, 8'h01);
        u_ledi2c_ctrl_model.stop_cond();
        model(8'hb0, 8'h12);
        check_outs();
        rd(8'hb0);
        check(v, 8'h12);
        // Stop part way through a data byte aborts it
        u_ledi2c_ctrl_model.start_cond();
        u_ledi2c_ctrl_model.byte_out(8'h6c, ack);
        u_ledi2c_ctrl_model.byte_out(8'ha0, ack);
        repeat (4) u_ledi2c_ctrl_model.bit_xfer(1'h0, ack);
        u_ledi2c_ctrl_model.stop_cond();
        check_outs();
        wr(8'h6c, 8'h80, 8'h00);
        check({7'h0, ack}, 8'h01);
        @(posedge clk_i);
        rstn_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'h1;
        defaults();
        repeat (4) @(posedge clk_i);
        check_outs();
        end_sim();
    end
endmodule
